// ---- hdl/adc_timing_regs.vh ----
// Purpose: Constants for the converter timing control block
// Assumes: 100 MHz system clock, one clock domain
// Notes: Field widths and cycle figures of the conversion sequence
// Contract
// - Basic clock is system clock over divider+1
// - Sample phase lasts extension plus two periods
// - Ten-bit conversion takes seventeen plus extension periods
// - Eight-bit conversion takes fifteen plus extension periods
// - Result register loaded within counted conversion time
// - Out-of-range input gives zero or full scale
`ifndef ADC_TIMING_REGS_VH
`define ADC_TIMING_REGS_VH
`define DIV_W          6
`define EXT_W          8
`define RES_W          10
`define SAMPLE_BASE    9'h002
`define CONV10_BASE    9'h011
`define CONV8_BASE     9'h00F
`define RES_ZERO       10'h000
`define RES_FULL       10'h3FF
`define SYS_FREQ_KHZ   100000
`define BCLK_MIN_KHZ   500
`define BCLK_MAX_KHZ   16500
`endif

// ---- hdl/basic_clock_gen.v ----
// Purpose: Divides the system clock into basic-clock ticks
// Assumes: Divider value stable while a conversion runs
// Notes: One-cycle tick every divider+1 system clocks
`timescale 1ns/1ns
`default_nettype none
`include "adc_timing_regs.vh"
module basic_clock_gen #(
	parameter DW = `DIV_W
) (
	input  wire          clk_sys,
	input  wire          rst,
	input  wire          run,
	input  wire [DW-1:0] divider,
	output wire          tick
);
	reg [DW-1:0] cnt_r;
	// Counter restarts when idle so the first tick is one full period after start
	assign tick = run && (cnt_r == divider);
	always @(posedge clk_sys) begin
		if (rst || !run || tick) begin
			cnt_r <= {DW{1'b0}};
		end else begin
			cnt_r <= cnt_r + 1'b1;
		end
	end
endmodule
`default_nettype wire

// ---- hdl/adc_conversion_timing.v ----
// Purpose: Sample and conversion phase sequencing of the converter
// Assumes: Request, settings and analog comparator inputs synchronous to clk_sys
// Notes: Settings are captured at request; basic clock range is software's concern
`timescale 1ns/1ns
`default_nettype none
`include "adc_timing_regs.vh"
module adc_conversion_timing #(
	parameter DW = `DIV_W,
	parameter EW = `EXT_W,
	parameter RW = `RES_W
) (
	input  wire          clk_sys,
	input  wire          rst,
	input  wire          startReq,
	input  wire [DW-1:0] basicClockDivider,
	input  wire [EW-1:0] sampleTimeExtension,
	input  wire          eightBitMode,
	input  wire          belowGround,
	input  wire          aboveReference,
	input  wire          compareHigh,
	output wire          busy,
	output reg           sampling_r,
	output reg  [RW-1:0] result_r,
	output reg           resultValid_r,
	output reg           done_r
);
	localparam [2:0] IDLE = 3'b001;
	localparam [2:0] SAMP = 3'b010;
	localparam [2:0] CONV = 3'b100;

	reg [2:0]    state_r;
	reg [2:0]    state_nxt;
	reg [DW-1:0] div_r;
	reg [EW-1:0] ext_r;
	reg          mode8_r;
	reg          clampLo_r;
	reg          clampHi_r;
	reg [8:0]    cnt_r;
	reg [RW-1:0] sar_r;
	reg [3:0]    bit_r;
	wire         tick;
	wire [8:0]   sampleLen;
	wire [8:0]   convLen;
	wire         sampEnd;
	wire         convEnd;
	wire [RW-1:0] trial;

	basic_clock_gen #(.DW(DW)) u_bclk (
		.clk_sys (clk_sys),
		.rst     (rst),
		.run     (!state_r[0]),
		.divider (div_r),
		.tick    (tick)
	);

	assign busy = !state_r[0];
	assign sampleLen = {1'b0, ext_r} + `SAMPLE_BASE;
	// Conversion phase length after sampling: total minus sample time
	assign convLen = mode8_r ? (`CONV8_BASE - `SAMPLE_BASE) : (`CONV10_BASE - `SAMPLE_BASE);
	wire          sampLast;
	wire          convLast;
	wire          accept;
	wire          bitStep;
	wire [8:0]    bitCount;

	// Phase ends are qualified by state so one counter can serve both phases
	assign sampLast = (cnt_r == sampleLen - 9'h001);
	assign convLast = (cnt_r == convLen - 9'h001);
	assign sampEnd  = tick && (state_r == SAMP) && sampLast;
	assign convEnd  = tick && (state_r == CONV) && convLast;
	assign trial    = sar_r | ({{(RW-1){1'b0}}, 1'b1} << bit_r);

	// Requests during a run are dropped without any indication
	assign accept   = (state_r == IDLE) && startReq;
	// 8-bit mode resolves the top eight bits only; the rest of the phase idles
	assign bitCount = mode8_r ? 9'h008 : 9'h00A;
	assign bitStep  = tick && (state_r == CONV) && (cnt_r < bitCount);

	// Timeline with T basic periods of D+1 system clocks each:
	// edge 0 takes the request and raises busy and the sample flag,
	// edge (S+2)(D+1) closes sampling and latches the clamp levels,
	// edge T(D+1) loads the result, pulses done and drops busy.
	// A new request is taken from the cycle in which done shows.
	always @* begin
		state_nxt = state_r;
		case (state_r)
			IDLE: begin
				if (startReq) begin
					state_nxt = SAMP;
				end
			end
			SAMP: begin
				if (sampEnd) begin
					state_nxt = CONV;
				end
			end
			CONV: begin
				if (convEnd) begin
					state_nxt = IDLE;
				end
			end
			default: begin
				state_nxt = IDLE;
			end
		endcase
	end

	always @(posedge clk_sys) begin
		if (rst) begin
			state_r <= IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Settings frozen at request, so a change mid-run cannot skew the timing
	always @(posedge clk_sys) begin
		if (rst) begin
			div_r   <= {DW{1'b0}};
			ext_r   <= {EW{1'b0}};
			mode8_r <= 1'b0;
		end else if (accept) begin
			div_r   <= basicClockDivider;
			ext_r   <= sampleTimeExtension;
			mode8_r <= eightBitMode;
		end
	end

	// Period counter restarts at request and at sample close, no idle period between
	always @(posedge clk_sys) begin
		if (rst) begin
			cnt_r <= 9'h000;
		end else if (accept) begin
			cnt_r <= 9'h000;
		end else if (sampEnd) begin
			cnt_r <= 9'h000;
		end else if (tick) begin
			cnt_r <= cnt_r + 9'h001;
		end
	end

	always @(posedge clk_sys) begin
		if (rst) begin
			sampling_r <= 1'b0;
		end else if (accept) begin
			sampling_r <= 1'b1;
		end else if (sampEnd || (state_r != SAMP)) begin
			sampling_r <= 1'b0;
		end
	end

	// Level held at sample close decides clamping; below ground wins
	always @(posedge clk_sys) begin
		if (rst) begin
			clampLo_r <= 1'b0;
			clampHi_r <= 1'b0;
		end else if (sampEnd) begin
			clampLo_r <= belowGround;
			clampHi_r <= aboveReference;
		end
	end

	// Successive approximation, most significant bit first, one bit per period
	always @(posedge clk_sys) begin
		if (rst) begin
			sar_r <= {RW{1'b0}};
			bit_r <= 4'h0;
		end else if (sampEnd) begin
			sar_r <= {RW{1'b0}};
			bit_r <= 4'h9;
		end else if (bitStep) begin
			if (compareHigh) begin
				sar_r <= trial;
			end
			bit_r <= bit_r - 4'h1;
		end
	end

	// Result load is the last step of the counted conversion time
	always @(posedge clk_sys) begin
		if (rst) begin
			result_r <= {RW{1'b0}};
		end else if (convEnd) begin
			if (clampLo_r) begin
				result_r <= `RES_ZERO;
			end else if (clampHi_r) begin
				result_r <= `RES_FULL;
			end else begin
				result_r <= sar_r;
			end
		end
	end

	// Valid stays up until the next request so software may read late
	always @(posedge clk_sys) begin
		if (rst) begin
			resultValid_r <= 1'b0;
		end else if (convEnd) begin
			resultValid_r <= 1'b1;
		end else if (accept) begin
			resultValid_r <= 1'b0;
		end
	end

	// Done marks the cycle in which the result first shows
	always @(posedge clk_sys) begin
		if (rst) begin
			done_r <= 1'b0;
		end else begin
			done_r <= convEnd;
		end
	end
endmodule
`default_nettype wire

// ---- tb/adc_conversion_timing_properties.sv ----
// Purpose: Timing checks of the conversion sequencer
// Assumes: Bench uses the fixed settings named here
// Notes: Fixed settings stand in for the general formulas
`timescale 1ns/1ns
`default_nettype none
module adc_conversion_timing_checker (
	input wire logic       clk_sys,
	input wire logic       rst,
	input wire logic       startReq,
	input wire logic [5:0] basicClockDivider,
	input wire logic [7:0] sampleTimeExtension,
	input wire logic       eightBitMode,
	input wire logic       busy,
	input wire logic       sampling_r,
	input wire logic       resultValid_r,
	input wire logic       done_r
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	wire take = startReq && !busy;
	wire base = take && basicClockDivider == 6'h06;
	wire ten  = !eightBitMode;
	// Divide by seven: sampling spans 14 clocks, done shows one edge late
	sequence sampleSpan; sampling_r ##13 sampling_r ##1 !sampling_r; endsequence
	sequence doneStep; !done_r ##1 done_r; endsequence
	sample_len_a: assert property (base && sampleTimeExtension == 8'h00 |=> sampleSpan)
		else $error("sample phase length wrong");
	plain_ten_a: assert property (base && sampleTimeExtension == 8'h00 && ten |-> ##119 doneStep)
		else $error("ten-bit time wrong");
	plain_eight_a: assert property (base && sampleTimeExtension == 8'h00 && eightBitMode |-> ##105 doneStep)
		else $error("eight-bit time wrong");
	divide_eight_a: assert property (take && basicClockDivider == 6'h07 && sampleTimeExtension == 8'h00 && ten |-> ##136 doneStep)
		else $error("divided time wrong");
	extend_three_a: assert property (base && sampleTimeExtension == 8'h03 && ten |-> ##140 doneStep)
		else $error("extended time wrong");
	done_pulse_a: assert property (done_r |-> resultValid_r ##1 (!done_r && !busy))
		else $error("done pulse wrong");
	valid_clear_a: assert property (take |=> busy && !resultValid_r)
		else $error("request not taken");
endmodule
bind adc_conversion_timing adc_conversion_timing_checker chk (.clk_sys(clk_sys), .rst(rst),
	.startReq(startReq), .basicClockDivider(basicClockDivider), .busy(busy),
	.sampleTimeExtension(sampleTimeExtension), .eightBitMode(eightBitMode),
	.sampling_r(sampling_r), .resultValid_r(resultValid_r), .done_r(done_r));
`default_nettype wire

// ---- tb/adc_conversion_timing_tb_top.sv ----
// Purpose: Self-checking bench of the conversion sequencer
// Assumes: Comparator held constant per row
// Notes: Rows give settings, cycle count and result
`timescale 1ns/1ns
`default_nettype none
module adc_conversion_timing_tb_top;
	typedef struct packed {
		logic [5:0]  d;
		logic [7:0]  s;
		logic [3:0]  mode;
		logic [15:0] cyc;
		logic [9:0]  res;
	} row_t;
	// Dividers of six and up keep the basic clock in range at 100 MHz
	row_t rows [6] = '{
		'{6'h06, 8'h00, 4'h1, 16'h0077, 10'h3FF}, '{6'h06, 8'h00, 4'h9, 16'h0069, 10'h3FC},
		'{6'h07, 8'h00, 4'h0, 16'h0088, 10'h000}, '{6'h06, 8'h03, 4'h6, 16'h008C, 10'h000},
		'{6'h08, 8'h03, 4'h2, 16'h00B4, 10'h3FF}, '{6'h3F, 8'hFF, 4'h1, 16'h4400, 10'h3FF}};
	logic       clk_sys = 0, rst = 1, startReq = 0, m = 0, bg = 0, ar = 0, ch = 0;
	logic [5:0] d = 6'h00;
	logic [7:0] s = 8'h00;
	logic [9:0] result_r;
	wire        busy, sampling_r, resultValid_r, done_r;
	int         err_total = 0, tests_run = 0;
	adc_conversion_timing dut (.clk_sys(clk_sys), .rst(rst), .startReq(startReq),
		.basicClockDivider(d), .sampleTimeExtension(s), .eightBitMode(m), .belowGround(bg),
		.aboveReference(ar), .compareHigh(ch), .busy(busy), .sampling_r(sampling_r),
		.result_r(result_r), .resultValid_r(resultValid_r), .done_r(done_r));
	always #5 clk_sys = ~clk_sys;
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("Error at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task finish_test;
		$display("Errors %0d of %0d checks", err_total, tests_run);
		if (err_total == 0 && tests_run > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// Extra request during the sample phase when inj is set; it must be ignored
	task automatic runConv(input row_t r, input logic inj);
		int n;
		@(posedge clk_sys);
		startReq <= 1'b1;
		{d, s, m, bg, ar, ch} <= {r.d, r.s, r.mode};
		@(posedge clk_sys);
		startReq <= 1'b0;
		n = 0;
		while (done_r !== 1'b1 && n < 20000) begin
			@(posedge clk_sys);
			startReq <= inj && n == 4;
			n++;
			#1;
		end
		chk(n[15:0], r.cyc);
		chk({6'h00, result_r}, {6'h00, r.res});
		chk({15'h0000, resultValid_r}, 16'h0001);
	endtask
	initial begin
		repeat (6) @(posedge clk_sys);
		rst <= 1'b0;
		for (int i = 0; i < 6; i++) runConv(rows[i], 1'b0);
		runConv(rows[0], 1'b1);
		runConv(rows[1], 1'b0);
		@(posedge clk_sys);
		rst <= 1'b1;
		@(posedge clk_sys);
		rst <= 1'b0;
		#1 chk({12'h000, busy, sampling_r, resultValid_r, done_r}, 16'h0000);
		// Reset in mid-conversion must drop the run at once
		@(posedge clk_sys);
		startReq <= 1'b1;
		{d, s, m, bg, ar, ch} <= {6'h06, 8'h00, 4'h1};
		@(posedge clk_sys);
		startReq <= 1'b0;
		repeat (20) @(posedge clk_sys);
		rst <= 1'b1;
		@(posedge clk_sys);
		rst <= 1'b0;
		#1 chk({12'h000, busy, sampling_r, resultValid_r, done_r}, 16'h0000);
		runConv(rows[0], 1'b0);
		finish_test;
	end
	initial begin
		#400000;
		err_total++;
		finish_test;
	end
endmodule
`default_nettype wire
